//--- pkg/usr_defines.vh
// register map, field positions and reset values of the status/data/baud block
`ifndef USR_DEFINES_VH
`define USR_DEFINES_VH
`define USR_OFS_STATUS 12'h000
`define USR_OFS_RXHOLD 12'h004
`define USR_OFS_TXHOLD 12'h008
`define USR_OFS_BAUD 12'h00C
`define USR_OFS_RXTO 12'h010
`define USR_OFS_CMD 12'h014
`define USR_OFS_MODE 12'h018
`define USR_CMD_RST_ITER 0
`define USR_CMD_RST_NON_ACKNOWLEDGE_FLAG 1
`define USR_CMD_TX_EN 2
`define USR_ST_TRANSMITTER_EMPTY 9
`define USR_ST_ITER 10
`define USR_ST_TX_DMA_BUFFER_EMPTY 11
`define USR_ST_RX_DMA_BUFFER_FULL 12
`define USR_ST_NON_ACKNOWLEDGE_FLAG 13
`define USR_ST_CHG_LSB 16
`define USR_ST_IMG_LSB 20
`define USR_ST_RECEIVER_READY 0
`define USR_ST_TRANSMITTER_READY 1
`define USR_SYNC_BIT 15
`define USR_MODE_ASYNC16 2'h0
`define USR_MODE_ASYNC8 2'h1
`define USR_MODE_SYNC 2'h2
`define USR_MODE_SCARD 2'h3
`define USR_RST_WORD 32'h00000000
`endif

//--- rtl/usr_buf2.v
// two-entry valid/ready buffer
`timescale 1ns/100ps
`default_nettype none
module usr_buf2 (
  input wire i_sys_clk,
  input wire i_rst,
  input wire i_in_valid,
  output wire o_in_ready,
  input wire [9:0] i_in_data,
  output wire o_out_valid,
  input wire i_out_ready,
  output wire [9:0] o_out_data
);
  reg [9:0] mem_q [0:1];
  reg rd_q;
  reg wr_q;
  reg [1:0] cnt_q;
  wire push;
  wire pop;
  assign o_in_ready = (cnt_q != 2'h2);
  assign o_out_valid = (cnt_q != 2'h0);
  assign o_out_data = mem_q[rd_q];
  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;
  always @(posedge i_sys_clk) begin
    if (i_rst) begin
      rd_q <= 1'b0;
      wr_q <= 1'b0;
      cnt_q <= 2'h0;
      mem_q[0] <= 10'h000;
      mem_q[1] <= 10'h000;
    end else begin
      if (push) begin
        mem_q[wr_q] <= i_in_data;
        wr_q <= ~wr_q;
      end
      if (pop) begin
        rd_q <= ~rd_q;
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + 2'h1;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - 2'h1;
      end
    end
  end
endmodule
`default_nettype wire

//--- rtl/usr_regs.v
// status, holding, baud and time-out registers of the serial block
//
// Implementation choices: the APB interface to the registers and the register addresses.
`timescale 1ns/100ps
`default_nettype none
`include "usr_defines.vh"
module usr_regs (
  input wire i_sys_clk,
  input wire i_rst,
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [11:0] i_paddr,
  input wire [31:0] i_pwdata,
  output reg [31:0] o_prdata,
  output reg o_pready,
  output reg o_pslverr,
  input wire i_tx_dma_buffer_empty,
  input wire i_rx_dma_buffer_full,
  input wire i_iteration_reached,
  input wire i_non_acknowledge_flag_detected,
  input wire [3:0] i_modem_lines,
  input wire i_rx_valid,
  input wire [9:0] i_rx_data,
  input wire i_bit_tick,
  output reg o_tx_valid,
  input wire i_tx_ready,
  output reg [9:0] o_tx_data,
  input wire i_tx_shift_busy,
  output reg o_baud_tick,
  output reg o_timeout
);
  // modem lines order: 0 ring, 1 set ready, 2 carrier, 3 clear to send
  reg [15:0] clock_divider_q;
  reg [2:0] fractional_part_q;
  reg [15:0] timeout_value_q;
  reg [10:0] smartcard_ratio_q;
  reg [1:0] mode_q;
  reg tx_en_q;
  reg iter_q;
  reg non_acknowledge_flag_q;
  reg [3:0] chg_q;
  reg [3:0] img_q;
  reg receiver_ready_q;
  reg [9:0] rx_hold_q;
  reg [29:0] acc_q;
  reg [15:0] to_cnt_q;
  reg buf_valid_d;
  reg [9:0] buf_data_d;
  reg wr_acc;
  reg rd_acc;
  reg [31:0] rdata_d;
  reg err_d;
  wire buf_ready;
  wire out_valid;
  wire [9:0] out_data;
  wire [29:0] step;
  wire [29:0] period;
  // wide enough for the largest divider times the largest smart-card ratio, in eighths
  function [29:0] usr_period;
    input [1:0] mode;
    input [15:0] cd;
    input [2:0] fp;
    input [10:0] ratio;
    reg [29:0] base;
    begin
      base = {11'h000, cd, fp};
      case (mode)
        `USR_MODE_ASYNC16: usr_period = {base[25:0], 4'h0};
        `USR_MODE_ASYNC8: usr_period = {base[26:0], 3'h0};
        `USR_MODE_SYNC: usr_period = base;
        default: usr_period = base * {19'h00000, ratio};
      endcase
    end
  endfunction
  assign period = usr_period(mode_q, clock_divider_q, fractional_part_q, smartcard_ratio_q);
  assign step = 30'h00000008;
  usr_buf2 u_buf (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_in_valid(buf_valid_d),
    .o_in_ready(buf_ready),
    .i_in_data(buf_data_d),
    .o_out_valid(out_valid),
    .i_out_ready(i_tx_ready && !(o_tx_valid)),
    .o_out_data(out_data)
  );
  always @* begin
    wr_acc = i_psel && i_penable && i_pwrite;
    rd_acc = i_psel && i_penable && !i_pwrite;
    buf_valid_d = wr_acc && !o_pready && (i_paddr == `USR_OFS_TXHOLD);
    buf_data_d = {i_pwdata[`USR_SYNC_BIT], i_pwdata[8:0]};
    err_d = 1'b0;
    rdata_d = `USR_RST_WORD;
    case (i_paddr)
      `USR_OFS_STATUS: begin
        rdata_d[`USR_ST_RECEIVER_READY] = receiver_ready_q;
        rdata_d[`USR_ST_TRANSMITTER_READY] = buf_ready && tx_en_q;
        rdata_d[`USR_ST_TRANSMITTER_EMPTY] = tx_en_q && !out_valid && !o_tx_valid && !i_tx_shift_busy;
        rdata_d[`USR_ST_ITER] = iter_q;
        rdata_d[`USR_ST_TX_DMA_BUFFER_EMPTY] = i_tx_dma_buffer_empty;
        rdata_d[`USR_ST_RX_DMA_BUFFER_FULL] = i_rx_dma_buffer_full;
        rdata_d[`USR_ST_NON_ACKNOWLEDGE_FLAG] = non_acknowledge_flag_q;
        rdata_d[19:16] = chg_q;
        rdata_d[23:20] = img_q;
      end
      `USR_OFS_RXHOLD: begin
        rdata_d[8:0] = rx_hold_q[8:0];
        rdata_d[`USR_SYNC_BIT] = rx_hold_q[9];
      end
      `USR_OFS_TXHOLD: rdata_d = `USR_RST_WORD;
      `USR_OFS_BAUD: rdata_d = {13'h0000, fractional_part_q, clock_divider_q};
      `USR_OFS_RXTO: rdata_d = {16'h0000, timeout_value_q};
      `USR_OFS_CMD: rdata_d = {31'h00000000, tx_en_q};
      `USR_OFS_MODE: rdata_d = {19'h00000, smartcard_ratio_q, mode_q};
      default: err_d = 1'b1;
    endcase
  end
  always @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_prdata <= 32'h00000000;
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
      clock_divider_q <= 16'h0000;
      fractional_part_q <= 3'h0;
      timeout_value_q <= 16'h0000;
      smartcard_ratio_q <= 11'h174;
      mode_q <= 2'h0;
      tx_en_q <= 1'b0;
      iter_q <= 1'b0;
      non_acknowledge_flag_q <= 1'b0;
      chg_q <= 4'h0;
      img_q <= 4'h0;
      receiver_ready_q <= 1'b0;
      rx_hold_q <= 10'h000;
      o_tx_valid <= 1'b0;
      o_tx_data <= 10'h000;
      acc_q <= 30'h00000000;
      o_baud_tick <= 1'b0;
      to_cnt_q <= 16'h0000;
      o_timeout <= 1'b0;
    end else begin
      // one wait state: ready pulses in the second access cycle
      o_pready <= i_psel && i_penable && !o_pready;
      o_pslverr <= i_psel && i_penable && !o_pready && err_d;
      if (rd_acc && !o_pready) begin
        o_prdata <= rdata_d;
      end
      img_q <= i_modem_lines;
      // clear in the cycle the read value is latched, so a change after it is kept
      if (rd_acc && !o_pready && i_paddr == `USR_OFS_STATUS) begin
        chg_q <= img_q ^ i_modem_lines;
      end else begin
        chg_q <= chg_q | (img_q ^ i_modem_lines);
      end
      if (i_iteration_reached) begin
        iter_q <= 1'b1;
      end else if (wr_acc && o_pready && i_paddr == `USR_OFS_CMD && i_pwdata[`USR_CMD_RST_ITER]) begin
        iter_q <= 1'b0;
      end
      if (i_non_acknowledge_flag_detected) begin
        non_acknowledge_flag_q <= 1'b1;
      end else if (wr_acc && o_pready && i_paddr == `USR_OFS_CMD && i_pwdata[`USR_CMD_RST_NON_ACKNOWLEDGE_FLAG]) begin
        non_acknowledge_flag_q <= 1'b0;
      end
      if (i_rx_valid) begin
        receiver_ready_q <= 1'b1;
        rx_hold_q <= i_rx_data;
      end else if (rd_acc && o_pready && i_paddr == `USR_OFS_RXHOLD) begin
        receiver_ready_q <= 1'b0;
      end
      if (wr_acc && o_pready) begin
        case (i_paddr)
          `USR_OFS_BAUD: begin
            clock_divider_q <= i_pwdata[15:0];
            fractional_part_q <= i_pwdata[18:16];
          end
          `USR_OFS_RXTO: timeout_value_q <= i_pwdata[15:0];
          `USR_OFS_CMD: tx_en_q <= i_pwdata[`USR_CMD_TX_EN];
          `USR_OFS_MODE: begin
            mode_q <= i_pwdata[1:0];
            smartcard_ratio_q <= i_pwdata[12:2];
          end
          default: tx_en_q <= tx_en_q;
        endcase
      end
      // output stage: one word on o_tx_data until accepted
      if (o_tx_valid && i_tx_ready) begin
        o_tx_valid <= 1'b0;
      end else if (!o_tx_valid && out_valid && i_tx_ready && tx_en_q) begin
        o_tx_valid <= 1'b1;
        o_tx_data <= out_data;
      end
      // fractional accumulator in eighths of a clock
      if (clock_divider_q == 16'h0000 || period == 30'h00000000) begin
        acc_q <= 30'h00000000;
        o_baud_tick <= 1'b0;
      end else if (acc_q + step >= period) begin
        acc_q <= acc_q + step - period;
        o_baud_tick <= 1'b1;
      end else begin
        acc_q <= acc_q + step;
        o_baud_tick <= 1'b0;
      end
      if (timeout_value_q == 16'h0000 || i_rx_valid) begin
        to_cnt_q <= 16'h0000;
        o_timeout <= 1'b0;
      end else if (i_bit_tick && !o_timeout) begin
        if (to_cnt_q + 16'h0001 == timeout_value_q) begin
          o_timeout <= 1'b1;
        end
        to_cnt_q <= to_cnt_q + 16'h0001;
      end
    end
  end
endmodule
`default_nettype wire

//--- verif/usr_peer.sv
// far-side transmitter model: takes words, then stays busy shifting each one
`timescale 1ns/100ps
`default_nettype none
module usr_peer (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_stall,
  input wire logic i_tx_valid,
  output logic o_tx_ready,
  output logic o_busy
);
  logic [1:0] busy_q;
  // no new word while a stall is asked or a word is still shifting
  assign o_tx_ready = !i_stall && busy_q == 2'h0;
  assign o_busy = busy_q != 2'h0;
  always @(posedge i_sys_clk) begin
    if (i_rst) begin
      busy_q <= 2'h0;
    end else if (i_tx_valid && o_tx_ready) begin
      busy_q <= 2'h3;
    end else if (busy_q != 2'h0) begin
      busy_q <= busy_q - 2'h1;
    end
  end
endmodule
`default_nettype wire

//--- verif/usr_regs_assertions.sv
// port checker of the serial block's registers
`timescale 1ns/100ps
`default_nettype none
module usr_regs_chk (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic i_tx_dma_buffer_empty,
  input wire logic i_rx_dma_buffer_full,
  input wire logic i_non_acknowledge_flag_detected,
  input wire logic [3:0] i_modem_lines,
  input wire logic i_tx_ready,
  input wire logic [31:0] o_prdata,
  input wire logic o_pready,
  input wire logic o_pslverr,
  input wire logic o_tx_valid,
  input wire logic [9:0] o_tx_data
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  wire acc = i_psel && i_penable && !o_pready;
  wire st_rd = acc && !i_pwrite && i_paddr == 12'h000;
  sequence non_acknowledge_flag_then_rd;
    i_non_acknowledge_flag_detected && i_psel && !i_penable ##1 st_rd;
  endsequence
  answer_wait_a: assert property (acc |=> o_pready) else $error("no answer after access");
  bad_addr_a: assert property (acc && !i_pwrite && i_paddr > 12'h018 |=> o_pslverr && o_prdata == 0)
    else $error("unmapped read not refused");
  buf_empty_img_a: assert property (st_rd |=> o_prdata[11] == $past(i_tx_dma_buffer_empty))
    else $error("buffer empty bit wrong");
  buf_full_img_a: assert property (st_rd |=> o_prdata[12] == $past(i_rx_dma_buffer_full))
    else $error("buffer full bit wrong");
  line_image_a: assert property (st_rd |=> o_prdata[23:20] == $past(i_modem_lines))
    else $error("line image wrong");
  line_change_a: assert property ($changed(i_modem_lines) ##[2:4] st_rd |=> o_prdata[19:16] != 0)
    else $error("line change lost");
  non_acknowledge_flag_sticky_a: assert property (non_acknowledge_flag_then_rd |=> o_prdata[13])
    else $error("non_acknowledge_flag flag not set");
  tx_hold_a: assert property (o_tx_valid && !i_tx_ready |=> o_tx_valid && $stable(o_tx_data))
    else $error("tx word dropped while stalled");
endmodule
bind usr_regs usr_regs_chk usr_regs_chk_inst (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_psel(i_psel),
  .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_tx_ready(i_tx_ready),
  .i_tx_dma_buffer_empty(i_tx_dma_buffer_empty), .i_rx_dma_buffer_full(i_rx_dma_buffer_full),
  .i_non_acknowledge_flag_detected(i_non_acknowledge_flag_detected), .i_modem_lines(i_modem_lines), .o_prdata(o_prdata),
  .o_pready(o_pready), .o_pslverr(o_pslverr), .o_tx_valid(o_tx_valid), .o_tx_data(o_tx_data));
`default_nettype wire

//--- verif/usr_regs_test.sv
// self-checking bench of the serial block's registers
`timescale 1ns/100ps
`default_nettype none
`include "usr_defines.vh"
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin errors++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (a), (e)); end end
module usr_regs_test;
  logic sys_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, rx_valid = 0, stall = 1;
  logic bufe = 0, buff = 0, iter = 0, non_acknowledge_flag = 0, tx_ready, busy, tx_valid, pready, pslverr, err, tick;
  logic bit_tick = 0, tmo;
  logic [3:0] lines = 4'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [9:0] rx_data = 10'h000, tx_data;
  logic [9:0] got[$];
  int errors = 0, comparisons = 0, cyc = 0, n;
  always #2.5 sys_clk = ~sys_clk;
  usr_regs usr_regs_inst (.i_sys_clk(sys_clk), .i_rst(rst), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_tx_dma_buffer_empty(bufe), .i_rx_dma_buffer_full(buff),
    .i_iteration_reached(iter), .i_non_acknowledge_flag_detected(non_acknowledge_flag), .i_modem_lines(lines),
    .i_rx_valid(rx_valid), .i_rx_data(rx_data), .i_bit_tick(bit_tick), .o_tx_valid(tx_valid),
    .i_tx_ready(tx_ready), .o_tx_data(tx_data), .i_tx_shift_busy(busy), .o_baud_tick(tick),
    .o_timeout(tmo));
  usr_peer usr_peer_inst (.i_sys_clk(sys_clk), .i_rst(rst), .i_stall(stall),
    .i_tx_valid(tx_valid), .o_tx_ready(tx_ready), .o_busy(busy));
  always @(posedge sys_clk) if (tx_valid === 1'b1 && tx_ready === 1'b1) got.push_back(tx_data);
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1) @(posedge sys_clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic t_status;
    bufe <= 1'b1;
    lines <= 4'hA;
    repeat (2) @(posedge sys_clk);
    apb(1'b0, `USR_OFS_STATUS, 32'h0);
    `CHK(rd[12:11], 2'h1)
    `CHK(rd[23:16], 8'hAA)
    bufe <= 1'b0;
    buff <= 1'b1;
    lines <= 4'h3;
    repeat (2) @(posedge sys_clk);
    apb(1'b0, `USR_OFS_STATUS, 32'h0);
    `CHK(rd[23:11], 13'h0722)
    apb(1'b0, `USR_OFS_STATUS, 32'h0);
    `CHK(rd[19:16], 4'h0)
  endtask
  task automatic t_sticky;
    non_acknowledge_flag <= 1'b1;
    iter <= 1'b1;
    apb(1'b0, `USR_OFS_STATUS, 32'h0);
    non_acknowledge_flag <= 1'b0;
    iter <= 1'b0;
    apb(1'b0, `USR_OFS_STATUS, 32'h0);
    `CHK({rd[13], rd[10]}, 2'h3)
    apb(1'b1, `USR_OFS_CMD, 32'h1);
    apb(1'b0, `USR_OFS_STATUS, 32'h0);
    `CHK({rd[13], rd[10]}, 2'h2)
    apb(1'b1, `USR_OFS_CMD, 32'h2);
    apb(1'b0, `USR_OFS_STATUS, 32'h0);
    `CHK({rd[13], rd[10]}, 2'h0)
  endtask
  task automatic t_rx;
    rx_data <= 10'h3A5;
    rx_valid <= 1'b1;
    @(posedge sys_clk);
    rx_valid <= 1'b0;
    apb(1'b0, `USR_OFS_STATUS, 32'h0);
    `CHK(rd[0], 1'b1)
    apb(1'b0, `USR_OFS_RXHOLD, 32'h0);
    `CHK(rd, 32'h000081A5)
    apb(1'b0, `USR_OFS_STATUS, 32'h0);
    `CHK(rd[0], 1'b0)
  endtask
  task automatic t_tx;
    int k;
    k = 0;
    apb(1'b1, `USR_OFS_CMD, 32'h4);
    // fill while the far side stalls, until the holding side refuses
    do begin
      apb(1'b1, `USR_OFS_TXHOLD, {16'h0, k[0], 6'h00, 9'h050 + k[8:0]});
      k++;
      apb(1'b0, `USR_OFS_STATUS, 32'h0);
    end while (rd[1] === 1'b1 && k < 6);
    `CHK(rd[9], 1'b0)
    stall <= 1'b0;
    n = 0;
    while ((got.size() < k || busy !== 1'b0 || tx_valid !== 1'b0 || n < 3) && n < 300) begin
      @(posedge sys_clk);
      n++;
    end
    `CHK(got.size(), k)
    foreach (got[i]) `CHK(got[i], {i[0], 9'h050 + i[8:0]})
    apb(1'b0, `USR_OFS_STATUS, 32'h0);
    `CHK(rd[9], 1'b1)
    apb(1'b1, `USR_OFS_CMD, 32'h0);
    apb(1'b0, `USR_OFS_STATUS, 32'h0);
    `CHK(rd[9], 1'b0)
  endtask
  task automatic t_regs;
    apb(1'b1, `USR_OFS_RXTO, 32'h0001FFFF);
    apb(1'b0, `USR_OFS_RXTO, 32'h0);
    `CHK(rd, 32'h0000FFFF)
    apb(1'b1, `USR_OFS_RXTO, 32'h3);
    repeat (2) begin
      bit_tick <= 1'b1;
      @(posedge sys_clk);
      bit_tick <= 1'b0;
      @(posedge sys_clk);
    end
    `CHK(tmo, 1'b0)
    bit_tick <= 1'b1;
    @(posedge sys_clk);
    bit_tick <= 1'b0;
    @(posedge sys_clk);
    `CHK(tmo, 1'b1)
    apb(1'b0, 12'h040, 32'h0);
    `CHK({err, rd}, {1'b1, 32'h0})
    apb(1'b1, `USR_OFS_BAUD, 32'h00050003);
    apb(1'b0, `USR_OFS_BAUD, 32'h0);
    `CHK(rd, 32'h00050003)
    // divide by 16 * (3 + 5/8) gives one tick every 58 clocks
    while (tick !== 1'b1) @(posedge sys_clk);
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (tick !== 1'b1 && n < 999);
    `CHK(n, 58)
  endtask
  task complete_run;
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      complete_run;
    end
  end
  initial begin
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    t_status;
    t_sticky;
    t_rx;
    t_tx;
    t_regs;
    complete_run;
  end
endmodule
`default_nettype wire
